// ---- rtl/ext_mem_interface_pkg.sv ----
// Constants and carrier types for the external memory interface
package ext_mem_interface_pkg;

    // ------------------------------------------------------------
    // Memory-map modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_INTERNAL  = 2'h0;
    localparam logic [1:0] MODE_SPLIT_NB  = 2'h1;
    localparam logic [1:0] MODE_SPLIT_BS  = 2'h2;
    localparam logic [1:0] MODE_EXTERNAL  = 2'h3;

    // ------------------------------------------------------------
    // Configuration field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_MUX_BIT   = 4;
    localparam int CFG_MODE_LSB  = 2;
    localparam int CFG_ALE_LSB   = 0;
    localparam logic [7:0] CFG_RESET = 8'h03;

    localparam int TC_SETUP_LSB  = 6;
    localparam int TC_STROBE_LSB = 2;
    localparam int TC_HOLD_LSB   = 0;
    localparam logic [7:0] TC_RESET = 8'hff;

    // ------------------------------------------------------------
    // Fixed overhead in system-clock cycles, wrap width in bits and internal RAM size in bytes
    // ------------------------------------------------------------
    localparam int FIXED_OVERHEAD = 4;
    localparam int WRAP_BITS      = 12;
    localparam int INT_RAM_BYTES  = 512;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       bus_mux_select;
        logic [1:0] memory_map_mode_field;
        logic [1:0] latch_strobe_width_field;
    } mem_cfg_t;

    typedef struct packed {
        logic [1:0] addr_setup_field;
        logic [3:0] strobe_width_field;
        logic [1:0] addr_hold_field;
    } bus_timing_t;

    typedef struct packed {
        logic        is_write;
        logic        is_16bit;
        logic        use_ptr_b;
        logic [7:0]  wdata;
    } xreq_t;

endpackage : ext_mem_interface_pkg

// ---- rtl/ext_mem_interface_decode.sv ----
// Effective-address and on/off-chip routing decode
module ext_mem_interface_decode #(
    parameter int INT_RAM_BYTES = ext_mem_interface_pkg::INT_RAM_BYTES
) (
    // Access description
    input  wire logic [1:0]  mode,
    input  wire logic        is_16bit,
    input  wire logic [15:0] data_pointer_reg,
    input  wire logic [7:0]  ext_data_ram_page_select,
    input  wire logic [7:0]  ind_ptr,
    // Result
    output logic [15:0] eff_addr,
    output logic        off_chip,
    output logic        drive_high
);

    logic [15:0] addr8;

    always_comb begin
        addr8    = {ext_data_ram_page_select, ind_ptr};
        eff_addr = is_16bit ? data_pointer_reg : addr8; // RQ8 RQ9 RQ16
        off_chip   = 1'b0;
        drive_high = 1'b1;
        case (mode)
            ext_mem_interface_pkg::MODE_INTERNAL: begin
                off_chip = 1'b0; // RQ7
            end
            ext_mem_interface_pkg::MODE_SPLIT_NB: begin
                off_chip = (32'(eff_addr) >= INT_RAM_BYTES); // RQ10 RQ12 RQ25
                drive_high = is_16bit; // RQ11
            end
            ext_mem_interface_pkg::MODE_SPLIT_BS: begin
                off_chip = (32'(eff_addr) >= INT_RAM_BYTES); // RQ12 RQ25
                drive_high = 1'b1; // RQ13
            end
            ext_mem_interface_pkg::MODE_EXTERNAL: begin
                off_chip   = 1'b1; // RQ14
                drive_high = is_16bit; // RQ15 RQ16
                if (!is_16bit) begin
                    eff_addr = {8'h00, ind_ptr}; // RQ15
                end
            end
            default: begin
                off_chip = 1'b0;
            end
        endcase
    end

endmodule : ext_mem_interface_decode

// ---- rtl/ext_mem_interface_core.sv ----
// External data memory interface: routing, bus muxing and bus timing
// ------------------------------------------------------------
// Functional notes
// RQ1 - Muxed mode shares eight pins for address/data
// RQ2 - Device drives the address-latch strobe
// RQ3 - Phase one: strobe high, low address out
// RQ4 - External latch holds from strobe fall
// RQ5 - Data owns shared pins at read/write strobe
// RQ6 - Non-muxed mode uses separate address, data pins
// RQ7 - Mode 00 goes on-chip, wraps at 4 kB
// RQ8 - Internal 8-bit: page select high, pointer low
// RQ9 - Internal 16-bit uses data pointer
// RQ10 - Mode 01 splits at internal size boundary
// RQ11 - Split no-bank 8-bit leaves upper pins undriven
// RQ12 - Split 16-bit drives all sixteen bits
// RQ13 - Mode 10 8-bit drives page and pointer
// RQ14 - Mode 11 all accesses go off-chip
// RQ15 - External 8-bit ignores page, upper undriven
// RQ16 - External 16-bit drives data pointer fully
// RQ17 - Setup, hold, strobe, latch widths programmable
// RQ18 - Access lasts parameters plus four cycles
// RQ19 - Muxed adds at least two strobe cycles
// RQ20 - Reset loads maximum setup and hold
// RQ21 - Mux select 0 muxed, 1 separate
// RQ22 - Latch width codes give 1 to 4 cycles
// RQ23 - Setup codes give 0 to 3 cycles
// RQ24 - On-chip accesses leave bus idle
// RQ25 - Internal size boundary is a parameter
// ------------------------------------------------------------
module ext_mem_interface_core #(
    parameter int INT_RAM_BYTES = ext_mem_interface_pkg::INT_RAM_BYTES,
    parameter int WRAP_BITS     = ext_mem_interface_pkg::WRAP_BITS
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // Configuration
    input  wire logic                  cfg_load,
    input  wire ext_mem_interface_pkg::mem_cfg_t    cfg_in,
    input  wire logic                  timing_load,
    input  wire ext_mem_interface_pkg::bus_timing_t timing_in,
    input  wire logic [7:0]            ext_data_ram_page_select,
    // Core request
    input  wire logic                  req_valid,
    input  wire ext_mem_interface_pkg::xreq_t       req,
    input  wire logic [15:0]           data_pointer_reg,
    input  wire logic [7:0]            indirect_pointer_a,
    input  wire logic [7:0]            indirect_pointer_b,
    output logic                       req_ready,
    output logic                       done,
    output logic [7:0]                 rdata,
    // On-chip data RAM port
    output logic                       iram_we,
    output logic                       iram_re,
    output logic [WRAP_BITS-1:0]       iram_addr,
    output logic [7:0]                 iram_wdata,
    input  wire logic [7:0]            iram_rdata,
    // Off-chip bus pins
    output logic [7:0]                 addr_hi_o,
    output logic                       addr_hi_oe,
    output logic [7:0]                 addr_lo_o,
    output logic                       addr_lo_oe,
    output logic [7:0]                 ad_o,
    output logic                       ad_oe,
    input  wire logic [7:0]            ad_i,
    output logic                       ale,
    output logic                       rd_n,
    output logic                       wr_n,
    // Status
    output ext_mem_interface_pkg::mem_cfg_t         cfg_out,
    output ext_mem_interface_pkg::bus_timing_t      timing_out
);

    typedef enum {
        ST_IDLE, ST_IRAM, ST_ALE_HI, ST_ALE_LO, ST_SETUP,
        ST_STROBE, ST_HOLD, ST_TAIL
    } state_t;

    state_t       state_reg;
    logic [3:0]   cnt_reg;
    logic [15:0]  addr_reg;
    logic         high_reg;
    logic         write_reg;
    logic [7:0]   wdata_reg;
    logic         mux_reg;

    logic [15:0]  eff_addr;
    logic         off_chip;
    logic         drive_high;
    logic [7:0]   ind_ptr;

    assign ind_ptr = req.use_ptr_b ? indirect_pointer_b : indirect_pointer_a;

    ext_mem_interface_decode #(
        .INT_RAM_BYTES (INT_RAM_BYTES)
    ) u_decode (
        .mode             (cfg_out.memory_map_mode_field),
        .is_16bit         (req.is_16bit),
        .data_pointer_reg (data_pointer_reg),
        .ext_data_ram_page_select (ext_data_ram_page_select),
        .ind_ptr          (ind_ptr),
        .eff_addr         (eff_addr),
        .off_chip         (off_chip),
        .drive_high       (drive_high)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_out    <= ext_mem_interface_pkg::CFG_RESET[4:0];
            timing_out <= ext_mem_interface_pkg::TC_RESET; // RQ20
        end else begin
            if (cfg_load) begin
                cfg_out <= cfg_in; // RQ17
            end
            if (timing_load) begin
                timing_out <= timing_in; // RQ17
            end
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    assign req_ready = (state_reg == ST_IDLE);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            addr_reg  <= 16'h0000;
            high_reg  <= 1'b0;
            write_reg <= 1'b0;
            wdata_reg <= 8'h00;
            mux_reg   <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (req_valid) begin
                        addr_reg  <= eff_addr;
                        high_reg  <= drive_high;
                        write_reg <= req.is_write;
                        wdata_reg <= req.wdata;
                        mux_reg   <= ~cfg_out.bus_mux_select; // RQ21
                        // Fixed overhead spans the decode and tail cycles
                        cnt_reg   <= 4'(ext_mem_interface_pkg::FIXED_OVERHEAD - 3); // RQ18
                        if (!off_chip) begin
                            state_reg <= ST_IRAM; // RQ24
                        end else if (!cfg_out.bus_mux_select) begin
                            cnt_reg   <= 4'(cfg_out.latch_strobe_width_field);
                            state_reg <= ST_ALE_HI; // RQ3
                        end else begin
                            cnt_reg   <= 4'(timing_out.addr_setup_field);
                            state_reg <= ST_SETUP;
                        end
                    end
                end
                ST_IRAM: begin
                    state_reg <= ST_IDLE;
                end
                ST_ALE_HI: begin
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= 4'(cfg_out.latch_strobe_width_field);
                        state_reg <= ST_ALE_LO; // RQ4
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1; // RQ22
                    end
                end
                ST_ALE_LO: begin
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= 4'(timing_out.addr_setup_field);
                        state_reg <= ST_SETUP;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1; // RQ19
                    end
                end
                ST_SETUP: begin
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= timing_out.strobe_width_field;
                        state_reg <= ST_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1; // RQ23
                    end
                end
                ST_STROBE: begin
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= 4'(timing_out.addr_hold_field);
                        state_reg <= ST_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1; // RQ17
                    end
                end
                ST_HOLD: begin
                    if (cnt_reg == 4'h0) begin
                        // Minimum setup and hold cycles count as overhead
                        cnt_reg   <= 4'(ext_mem_interface_pkg::FIXED_OVERHEAD - 3);
                        state_reg <= ST_TAIL;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                ST_TAIL: begin
                    if (cnt_reg == 4'h0) begin
                        state_reg <= ST_IDLE; // RQ18
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data capture and completion
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state_reg == ST_IRAM) begin
                done <= 1'b1;
                if (!write_reg) begin
                    rdata <= iram_rdata;
                end
            end
            if (state_reg == ST_STROBE && cnt_reg == 4'h0 && !write_reg) begin
                rdata <= ad_i;
            end
            if (state_reg == ST_TAIL && cnt_reg == 4'h0) begin
                done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // On-chip RAM port
    // ------------------------------------------------------------
    always_comb begin
        iram_addr  = addr_reg[WRAP_BITS-1:0]; // RQ7
        iram_wdata = wdata_reg;
        iram_we    = (state_reg == ST_IRAM) && write_reg;
        iram_re    = (state_reg == ST_IRAM) && !write_reg;
    end

    // ------------------------------------------------------------
    // Off-chip pins
    // ------------------------------------------------------------
    logic bus_active;
    logic strobe_on;

    always_comb begin
        bus_active = !(state_reg == ST_IDLE || state_reg == ST_IRAM); // RQ24
        strobe_on  = (state_reg == ST_STROBE);
        ale        = (state_reg == ST_ALE_HI); // RQ2 RQ3
        rd_n       = !(strobe_on && !write_reg);
        wr_n       = !(strobe_on && write_reg);
        addr_hi_o  = addr_reg[15:8];
        addr_hi_oe = bus_active && high_reg; // RQ11 RQ12 RQ13 RQ15
        addr_lo_o  = addr_reg[7:0];
        addr_lo_oe = bus_active && !mux_reg; // RQ6
        if (mux_reg) begin
            // Low address first, then data at the strobe
            if (state_reg == ST_ALE_HI || state_reg == ST_ALE_LO) begin
                ad_o  = addr_reg[7:0]; // RQ1 RQ3
                ad_oe = 1'b1;
            end else begin
                ad_o  = wdata_reg; // RQ5
                ad_oe = write_reg && bus_active && state_reg != ST_TAIL;
            end
        end else begin
            ad_o  = wdata_reg; // RQ6
            ad_oe = write_reg && bus_active && state_reg != ST_TAIL;
        end
    end

endmodule : ext_mem_interface_core

// ---- testbench/ext_mem_interface_monitor.sv ----
// Pin-level assertions for the external memory interface
module ext_mem_interface_monitor (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rstn,
    // Configuration
    input wire ext_mem_interface_pkg::mem_cfg_t    cfg_out,
    input wire ext_mem_interface_pkg::bus_timing_t timing_out,
    // On-chip RAM enables and bus pins
    input wire logic                  iram_we,
    input wire logic                  iram_re,
    input wire logic                  addr_lo_oe,
    input wire logic                  ad_oe,
    input wire logic                  ale,
    input wire logic                  rd_n,
    input wire logic                  wr_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [4:0] ale_cnt_reg;
    logic [4:0] stb_cnt_reg;
    // ------------------------------------------------------------
    // Pulse width counters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) ale_cnt_reg <= 5'h00;
        else ale_cnt_reg <= ale ? ale_cnt_reg + 5'h01 : 5'h00;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) stb_cnt_reg <= 5'h00;
        else stb_cnt_reg <= (rd_n && wr_n) ? 5'h00 : stb_cnt_reg + 5'h01;
    end
    sequence s_ale_end; $fell(ale); endsequence
    sequence s_strobe; !(rd_n && wr_n); endsequence
    property p_ale_width;
        s_ale_end |->
            ale_cnt_reg == 5'(cfg_out.latch_strobe_width_field) + 5'h01;
    endproperty
    property p_stb_width;
        $rose(rd_n && wr_n) |->
            stb_cnt_reg == 5'(timing_out.strobe_width_field) + 5'h01;
    endproperty
    property p_latch_order; s_ale_end |-> ##[1:9] s_strobe; endproperty
    property p_addr_phase;
        ale |-> ad_oe && !addr_lo_oe && !cfg_out.bus_mux_select;
    endproperty
    property p_wr_data; !wr_n |-> ad_oe; endproperty
    property p_rd_free; !rd_n |-> !ad_oe; endproperty
    property p_sep_addr;
        cfg_out.bus_mux_select && !(rd_n && wr_n) |-> addr_lo_oe;
    endproperty
    property p_onchip_quiet;
        iram_re || iram_we |-> rd_n && wr_n && !ale && !ad_oe;
    endproperty
    property p_reset_vals;
        !$past(rstn) |-> cfg_out == 5'h03 && timing_out == 8'hff;
    endproperty
    a_ale_width: assert property (p_ale_width)
        else $error("latch strobe width wrong");
    a_stb_width: assert property (p_stb_width)
        else $error("read or write strobe width wrong");
    a_latch_order: assert property (p_latch_order)
        else $error("no strobe after latch phase");
    a_addr_phase: assert property (p_addr_phase)
        else $error("address phase pins wrong");
    a_wr_data: assert property (p_wr_data)
        else $error("write data not driven");
    a_rd_free: assert property (p_rd_free)
        else $error("data pins driven during read");
    a_sep_addr: assert property (p_sep_addr)
        else $error("separate address pins idle");
    a_onchip_quiet: assert property (p_onchip_quiet)
        else $error("bus active in on-chip cycle");
    a_reset_vals: assert property (p_reset_vals)
        else $error("configuration not at reset value");
endmodule : ext_mem_interface_monitor

bind ext_mem_interface_core ext_mem_interface_monitor u_mon (
    .ref_clk(ref_clk), .rstn(rstn), .cfg_out(cfg_out),
    .timing_out(timing_out), .iram_we(iram_we), .iram_re(iram_re),
    .addr_lo_oe(addr_lo_oe), .ad_oe(ad_oe), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n)
);

// ---- testbench/ext_ram_model.sv ----
// Behavioural external RAM behind a transparent low-address latch
module ext_ram_model #(
    parameter logic [7:0] PORT_LATCH_HI = 8'hee
) (
    // Clock and board wiring
    input wire logic       ref_clk,
    input wire logic       mux_wired,
    // Device pins
    input wire logic [7:0] addr_hi_o,
    input wire logic       addr_hi_oe,
    input wire logic [7:0] addr_lo_o,
    input wire logic [7:0] ad_o,
    input wire logic       ad_oe,
    input wire logic       ale,
    input wire logic       rd_n,
    input wire logic       wr_n,
    output logic [7:0]     ad_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [0:65535];
    logic [7:0]  lat_reg;
    logic [7:0]  last_reg = 8'h00;
    logic [15:0] addr;
    always_latch begin
        if (ale) lat_reg <= ad_o;
    end
    // Undriven upper pins keep the port latch value
    assign addr = {addr_hi_oe ? addr_hi_o : PORT_LATCH_HI,
                   mux_wired ? lat_reg : addr_lo_o};
    always @(negedge ref_clk) begin
        if (!wr_n) mem[addr] <= ad_o;
        if (!rd_n) last_reg <= mem[addr];
    end
    assign ad_i = ad_oe ? ad_o : (!rd_n ? mem[addr] : ~last_reg);
endmodule : ext_ram_model

// ---- testbench/ext_memory_mode_timing_bench.sv ----
// Self-checking bench for the external memory interface block
module ext_memory_mode_timing_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        int cyc;
        int len;
        logic rd;
        logic known;
        logic [7:0] d;
    } note_t;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_load = 1'b0;
    logic timing_load = 1'b0;
    logic req_valid = 1'b0;
    ext_mem_interface_pkg::mem_cfg_t cfg_in = '0;
    ext_mem_interface_pkg::mem_cfg_t cur_cfg = 5'h03;
    ext_mem_interface_pkg::bus_timing_t timing_in = '0;
    ext_mem_interface_pkg::bus_timing_t cur_tim = 8'hff;
    ext_mem_interface_pkg::xreq_t req = '0;
    logic [15:0] data_pointer_reg = 16'h0000;
    logic [7:0] ext_data_ram_page_select = 8'h00;
    logic [7:0] indirect_pointer_a = 8'h00;
    logic [7:0] indirect_pointer_b = 8'h00;
    logic [7:0] rnd = 8'h1a;
    logic [15:0] ra;
    logic [7:0] rdata, iram_wdata, iram_rdata, ad_i, addr_hi_o, addr_lo_o;
    logic [7:0] ad_o;
    logic [11:0] iram_addr;
    logic req_ready, done, iram_we, iram_re, ale, rd_n, wr_n;
    logic addr_hi_oe, addr_lo_oe, ad_oe;
    ext_mem_interface_pkg::mem_cfg_t cfg_out;
    ext_mem_interface_pkg::bus_timing_t timing_out;
    logic [7:0] iram_mem [0:4095];
    logic [7:0] ext_ref [logic [15:0]];
    logic [7:0] int_ref [logic [11:0]];
    note_t notes [$];
    note_t w;
    int cyc = 0;
    int compares = 0;
    int miscompares = 0;
    ext_mem_interface_core uut (
        .ref_clk(ref_clk), .rstn(rstn), .cfg_load(cfg_load),
        .cfg_in(cfg_in), .timing_load(timing_load), .timing_in(timing_in),
        .ext_data_ram_page_select(ext_data_ram_page_select), .req_valid(req_valid),
        .req(req), .data_pointer_reg(data_pointer_reg),
        .indirect_pointer_a(indirect_pointer_a),
        .indirect_pointer_b(indirect_pointer_b), .req_ready(req_ready),
        .done(done), .rdata(rdata), .iram_we(iram_we), .iram_re(iram_re),
        .iram_addr(iram_addr), .iram_wdata(iram_wdata),
        .iram_rdata(iram_rdata), .addr_hi_o(addr_hi_o),
        .addr_hi_oe(addr_hi_oe), .addr_lo_o(addr_lo_o),
        .addr_lo_oe(addr_lo_oe), .ad_o(ad_o), .ad_oe(ad_oe), .ad_i(ad_i),
        .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .cfg_out(cfg_out),
        .timing_out(timing_out));
    ext_ram_model ram (
        .ref_clk(ref_clk), .mux_wired(!cur_cfg.bus_mux_select),
        .addr_hi_o(addr_hi_o), .addr_hi_oe(addr_hi_oe), .ale(ale),
        .addr_lo_o(addr_lo_o), .ad_o(ad_o), .ad_oe(ad_oe),
        .rd_n(rd_n), .wr_n(wr_n), .ad_i(ad_i));
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    always @(posedge ref_clk) begin
        if (iram_we === 1'b1) iram_mem[iram_addr] <= iram_wdata;
    end
    assign iram_rdata = iram_re ? iram_mem[iram_addr] : cyc[7:0];
    function automatic logic [16:0] route(input logic [1:0] m,
        input logic w16, input logic [15:0] dp, input logic [7:0] pg,
        input logic [7:0] p);
        logic [15:0] a;
        a = w16 ? dp : {pg, p};
        if (m == 2'h0) return {5'h00, a[11:0]};
        if (m != 2'h3 && a < ext_mem_interface_pkg::INT_RAM_BYTES) return {1'b0, a};
        if (!w16 && m != 2'h2) a[15:8] = 8'hee;
        return {1'b1, a};
    endfunction : route
    task automatic chk(input string s, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic wait_ready;
        int k;
        k = 0;
        while (req_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1 k++;
            if (k > 300) miscompares++;
            if (k > 300) complete_run();
        end
    endtask : wait_ready
    task automatic setup(input logic m, input logic [1:0] md, a,
                         input logic lt, input logic [7:0] t);
        req_valid = 1'b0;
        wait_ready();
        cfg_in = '{m, md, a};
        timing_in = t;
        cfg_load = 1'b1;
        timing_load = lt;
        @(posedge ref_clk);
        #1 cfg_load = 1'b0;
        timing_load = 1'b0;
        cur_cfg = cfg_in;
        if (lt) cur_tim = timing_in;
    endtask : setup
    task automatic acc(input logic wr, w16, input logic [15:0] dp,
                       input logic [7:0] pg, p);
        logic [16:0] r;
        note_t n;
        r = route(cur_cfg.memory_map_mode_field, w16, dp, pg, p);
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        req = '{wr, w16, rnd[0], rnd};
        data_pointer_reg = dp;
        ext_data_ram_page_select = pg;
        indirect_pointer_a = rnd[0] ? ~p : p;
        indirect_pointer_b = rnd[0] ? p : ~p;
        req_valid = 1'b1;
        wait_ready();
        @(posedge ref_clk);
        #1 n.cyc = cyc;
        n.len = r[16] ? 5 + cur_tim.addr_setup_field + cur_tim.addr_hold_field
            + cur_tim.strobe_width_field : 1;
        if (r[16] && !cur_cfg.bus_mux_select)
            n.len += 2 + 2 * cur_cfg.latch_strobe_width_field;
        n.rd = !wr;
        n.d = rnd;
        n.known = r[16] ? ext_ref.exists(r[15:0]) : int_ref.exists(r[11:0]);
        if (wr && r[16]) ext_ref[r[15:0]] = rnd;
        else if (wr) int_ref[r[11:0]] = rnd;
        else if (n.known) n.d = r[16] ? ext_ref[r[15:0]] : int_ref[r[11:0]];
        notes.push_back(n);
    endtask : acc
    // ------------------------------------------------------------
    // Result watcher and main sequence
    // ------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (rstn && done === 1'b1 && notes.size() == 0) begin
            chk("spurious done", 16'h0000, 16'h0001);
        end else if (rstn && done === 1'b1) begin
            w = notes.pop_front();
            chk("cycles", 16'(w.len), 16'(cyc - w.cyc));
            if (w.rd && w.known) chk("rdata", 16'(w.d), 16'(rdata));
        end
    end
    initial begin
        #200000 miscompares++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        #1 rstn = 1'b1;
        chk("cfg_out", 16'h0003, 16'(cfg_out));
        chk("timing_out", 16'h00ff, 16'(timing_out));
        setup(1'b0, 2'h3, 2'h3, 1'b0, 8'h00);
        acc(1'b1, 1'b1, 16'h0010, 8'h00, 8'h00);
        acc(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00);
        setup(1'b1, 2'h0, 2'h0, 1'b1, 8'h04);
        acc(1'b1, 1'b1, 16'h1005, 8'h00, 8'h00);
        acc(1'b0, 1'b1, 16'h2005, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 16'h0000, 8'h00, 8'h10);
        setup(1'b0, 2'h1, 2'h0, 1'b1, 8'h04);
        acc(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 16'h0000, 8'h05, 8'h21);
        acc(1'b0, 1'b1, 16'hee21, 8'h00, 8'h00);
        setup(1'b1, 2'h2, 2'h0, 1'b1, 8'h04);
        acc(1'b1, 1'b0, 16'h0000, 8'h12, 8'h56);
        acc(1'b0, 1'b1, 16'h1256, 8'h00, 8'h00);
        setup(1'b0, 2'h3, 2'h1, 1'b1, 8'h04);
        acc(1'b0, 1'b0, 16'h0000, 8'h12, 8'h21);
        acc(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00);
        for (int i = 0; i < 16; i++) begin
            setup(i[0], rnd[1:0], i[2:1], 1'b1, {i[3:2], i[3:0], i[1:0]});
            ra = {rnd, ~rnd};
            acc(1'b1, 1'b1, ra, 8'h00, 8'h00);
            acc(1'b0, 1'b1, ra, 8'h00, 8'h00);
            acc(1'b1, 1'b0, 16'h0000, ra[15:8], ra[7:0]);
            acc(1'b0, 1'b0, 16'h0000, ra[15:8], ra[7:0]);
        end
        setup(1'b1, 2'h0, 2'h0, 1'b0, 8'h00);
        @(posedge ref_clk);
        chk("notes left", 16'h0000, 16'(notes.size()));
        complete_run();
    end
endmodule : ext_memory_mode_timing_bench
